// >>> src/gacd_pin.sv
module gacd_pin #(
  parameter int PRESCALE_MAX = 128
) (
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Configuration from the control register.
  input  wire logic [1:0]            pin_mode_sel,
  input  wire logic [7:0]            prescale_m,
  input  wire logic [15:0]           thresh_high,
  input  wire logic [15:0]           thresh_low,
  // Charge events from the integrator and the battery monitor.
  input  wire logic                  charge_up,
  input  wire logic                  charge_down,
  input  wire logic                  vbat_low,
  input  wire logic                  undervoltage_lockout_event,
  // Host status read strobe.
  input  wire logic                  status_read,
  // Shared pin, split into its three signals.
  input  wire logic                  alert_or_charge_done_pin_in,
  output logic                       alert_or_charge_done_pin_out,
  output logic                       alert_or_charge_done_pin_oe,
  // Observed state.
  output logic [15:0]                accumulated_charge_count,
  output gacd_pkg::gacd_status_t     status,
  output logic                       charge_done_seen
);

  // Elaboration-time checks: the prescaler and the pulse counter are eight bits wide.
  if (PRESCALE_MAX < 1 || PRESCALE_MAX > 128)
  begin
    $error("PRESCALE_MAX must lie between 1 and 128.");
  end
  if (gacd_pkg::CHARGE_DONE_MIN_CYC < 1 || gacd_pkg::CHARGE_DONE_MIN_CYC > 255)
  begin
    $error("The charge-done pulse length must fit the eight-bit pulse counter.");
  end

  gacd_pkg::gacd_mode_t mode;
  logic       cd_meta;
  logic       cd_sync;
  logic [7:0] prescale_acc;
  logic       step_up;
  logic       step_down;
  logic       alert_any;
  logic [7:0] pulse_len;

  // Decode the select field; the disabled code leaves the pin idle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode <= gacd_pkg::GACD_ALERT;
    else
    begin
      unique case (pin_mode_sel)
        gacd_pkg::PIN_MODE_ALERT:  mode <= gacd_pkg::GACD_ALERT;
        gacd_pkg::PIN_MODE_CHARGE: mode <= gacd_pkg::GACD_CHARGE;
        default:                   mode <= gacd_pkg::GACD_IDLE;
      endcase
    end
  end

  // Two-flop synchroniser; only the second flop is read by the logic.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cd_meta <= 1'b0;
      cd_sync <= 1'b0;
    end
    else
    begin
      cd_meta <= alert_or_charge_done_pin_in;
      cd_sync <= cd_meta;
    end
  end

  // Pulse width counter; a 1 us pulse spans many clocks, so a high sample is never missed.
  // It restarts when the input drops or the mode leaves charge-done, so N means N samples in a row.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pulse_len <= 8'h00;
    else if (cd_sync && mode == gacd_pkg::GACD_CHARGE)
    begin
      if (pulse_len != 8'hFF)
        pulse_len <= pulse_len + 8'h01;
    end
    else
      pulse_len <= 8'h00;
  end

  // Registered view of a recognised charge-done level, three clocks after the pin.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      charge_done_seen <= 1'b0;
    else
      charge_done_seen <= (mode == gacd_pkg::GACD_CHARGE) && cd_sync;
  end

  // Prescaler: the count steps once per M integrator events in either direction.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_acc <= 8'h00;
      step_up      <= 1'b0;
      step_down    <= 1'b0;
    end
    else
    begin
      step_up   <= 1'b0;
      step_down <= 1'b0;
      if (charge_up && !charge_down)
      begin
        if (prescale_acc + 8'h01 >= prescale_m)
        begin
          prescale_acc <= 8'h00;
          step_up      <= 1'b1;
        end
        else
          prescale_acc <= prescale_acc + 8'h01;
      end
      else if (charge_down && !charge_up)
      begin
        if (prescale_acc == 8'h00)
        begin
          prescale_acc <= (prescale_m == 8'h00) ? 8'h00 : prescale_m - 8'h01;
          step_down    <= 1'b1;
        end
        else
          prescale_acc <= prescale_acc - 8'h01;
      end
    end
  end

  // Charge counter with preset while charge-done is high and saturation at limits.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      accumulated_charge_count <= gacd_pkg::COUNT_RESET;
    else if (mode == gacd_pkg::GACD_CHARGE && cd_sync)
      accumulated_charge_count <= gacd_pkg::COUNT_FULL;
    else if (step_up && accumulated_charge_count != gacd_pkg::COUNT_FULL)
      accumulated_charge_count <= accumulated_charge_count + 16'h0001;
    else if (step_down && accumulated_charge_count != gacd_pkg::COUNT_EMPTY)
      accumulated_charge_count <= accumulated_charge_count - 16'h0001;
  end

  // Sticky status flags; a set in the same cycle as a read wins over the clear.
  // The read strobe comes from a receive-clock-only serial slave, far slower than this clock.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      status <= '0;
    else
    begin
      status.overflow <= (step_up && accumulated_charge_count == gacd_pkg::COUNT_FULL)
        || (step_down && accumulated_charge_count == gacd_pkg::COUNT_EMPTY)
        || (status.overflow && !status_read);
      status.alert_high <= (accumulated_charge_count > thresh_high)
        || (status.alert_high && !status_read);
      status.alert_low <= (accumulated_charge_count < thresh_low)
        || (status.alert_low && !status_read);
      status.vbat_alert <= vbat_low || (status.vbat_alert && !status_read);
      status.undervoltage_lockout <= undervoltage_lockout_event
        || (status.undervoltage_lockout && !status_read);
    end
  end

  assign alert_any = status.overflow || status.alert_high || status.alert_low
    || status.vbat_alert;

  // Open-drain drive: only low is ever driven, and only in alert mode.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe  <= 1'b0;
    end
    else
    begin
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe  <= (mode == gacd_pkg::GACD_ALERT) && alert_any;
    end
  end

  // Assertions.
  a_pin_not_driven: assert property (@(posedge clock) disable iff (!rst_n)
    mode != gacd_pkg::GACD_ALERT |=> !alert_or_charge_done_pin_oe)
    else $error("Pin driven outside alert mode.");
  a_preset_full: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == gacd_pkg::GACD_CHARGE && cd_sync) |=> accumulated_charge_count == 16'hFFFF)
    else $error("Count not preset to full scale.");
  a_sync_delay: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(alert_or_charge_done_pin_in) ##1 alert_or_charge_done_pin_in
    |=> $rose(cd_sync) || cd_sync)
    else $error("Charge-done input not synchronised in two cycles.");
  a_count_no_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    $past(accumulated_charge_count) == 16'hFFFF && !cd_sync
    |-> accumulated_charge_count != 16'h0000)
    else $error("Count wrapped from full to empty.");
  a_alert_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == gacd_pkg::GACD_ALERT && alert_any) |=> alert_or_charge_done_pin_oe)
    else $error("Alert not driven low.");
  a_undervoltage_lockout_silent: assert property (@(posedge clock) disable iff (!rst_n)
    (!alert_any) |=> !alert_or_charge_done_pin_oe)
    else $error("Pin pulled low without a qualifying flag.");
  a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    step_up && !(mode == gacd_pkg::GACD_CHARGE && cd_sync)
      && accumulated_charge_count != 16'hFFFF
    |=> accumulated_charge_count == $past(accumulated_charge_count) + 16'h0001)
    else $error("Count did not step up by one.");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    status.vbat_alert && !status_read |=> status.vbat_alert)
    else $error("Flag dropped without a read.");
  a_pulse_caught: assert property (@(posedge clock) disable iff (!rst_n)
    pulse_len == 8'(gacd_pkg::CHARGE_DONE_MIN_CYC)
    |-> charge_done_seen && accumulated_charge_count == gacd_pkg::COUNT_FULL)
    else $error("Minimum-width charge-done pulse not recognised.");

endmodule

// >>> src/gacd_pkg.sv
package gacd_pkg;

  // Pin function select field values; reset value selects alert mode.
  localparam logic [1:0] PIN_MODE_ALERT    = 2'h2;
  localparam logic [1:0] PIN_MODE_CHARGE   = 2'h1;
  localparam logic [1:0] PIN_MODE_DISABLED = 2'h0;
  localparam logic [1:0] PIN_MODE_RESET    = 2'h2;

  // Charge count limits and reset value.
  localparam logic [15:0] COUNT_FULL  = 16'hFFFF;
  localparam logic [15:0] COUNT_EMPTY = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h7FFF;

  // Prescaler reset factor and the charge step in micro-mAh at the top factor.
  localparam logic [7:0] PRESCALE_RESET = 8'h80;
  localparam int         LSB_MICRO_MAH  = 85;
  localparam int         LSB_DIVISOR    = 128;

  // Least charge-done pulse and the clock.
  localparam int CLOCK_MHZ            = 100;
  localparam int CHARGE_DONE_MIN_NS   = 1000;
  localparam int CHARGE_DONE_MIN_CYC  = (CHARGE_DONE_MIN_NS * CLOCK_MHZ + 999) / 1000;

  // Pin function state.
  typedef enum logic [1:0] {
    GACD_ALERT  = 2'b00,
    GACD_CHARGE = 2'b01,
    GACD_IDLE   = 2'b10
  } gacd_mode_t;

  // Status flags that the counter, the comparators and the battery monitor raise.
  typedef struct packed {
    logic overflow;
    logic alert_high;
    logic alert_low;
    logic vbat_alert;
    logic undervoltage_lockout;
  } gacd_status_t;

endpackage

// >>> verification/gacd_charger.sv
module gacd_charger (
  // Clock.
  input  wire logic        clock,
  // Bench control.
  input  wire logic        attached,
  input  wire logic        start,
  input  wire logic [15:0] width,
  // Shared pin.
  input  wire logic        pin_oe,
  output logic             pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left = 16'h0000;
  // The pulse is counted in device clocks, so its width is exact to the cycle.
  always @(posedge clock)
  begin
    if (start)
      left <= width;
    else if (left != 16'h0000)
      left <= left - 16'h0001;
  end
  // Open drain wins; a detached charger leaves the pull-up holding the line high.
  assign pin_level = pin_oe ? 1'b0 : (attached ? (left != 16'h0000) : 1'b1);
endmodule

// >>> verification/gauge_alert_charge_done_pin_bench.sv
module gauge_alert_charge_done_pin_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, charge_up = 1'b0, charge_down = 1'b0;
  logic vbat_low = 1'b0, undervoltage_lockout_event = 1'b0, status_read = 1'b0, attached = 1'b0, start = 1'b0;
  logic [1:0]  pin_mode_sel = gacd_pkg::PIN_MODE_RESET;
  logic [7:0]  prescale_m   = 8'h01;
  logic [15:0] thresh_high  = 16'hFFFF;
  logic [15:0] thresh_low   = 16'h0000;
  logic        pin_in, pin_out, pin_oe, seen;
  logic [15:0] count;
  gacd_pkg::gacd_status_t status;
  int num_errors = 0;
  int checks = 0;
  // Free-running device clock at 100 MHz.
  initial forever #5 clock = ~clock;
  gacd_pin gacd_pin_i (.clock(clock), .rst_n(rst_n), .pin_mode_sel(pin_mode_sel),
    .prescale_m(prescale_m), .thresh_high(thresh_high), .thresh_low(thresh_low),
    .charge_up(charge_up), .charge_down(charge_down), .vbat_low(vbat_low),
    .undervoltage_lockout_event(undervoltage_lockout_event), .status_read(status_read),
    .alert_or_charge_done_pin_in(pin_in), .alert_or_charge_done_pin_out(pin_out),
    .alert_or_charge_done_pin_oe(pin_oe), .accumulated_charge_count(count),
    .status(status), .charge_done_seen(seen));
  gacd_charger gacd_charger_i (.clock(clock), .attached(attached), .start(start),
    .width(16'(gacd_pkg::CHARGE_DONE_MIN_CYC)), .pin_oe(pin_oe), .pin_level(pin_in));
  // Summary and verdict; the only place the run ends.
  task automatic give_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  // Sampling just after the edge lets that edge's register updates land first.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One-cycle integrator event, up or down.
  task automatic nudge(input logic up);
    @(posedge clock);
    if (up) charge_up <= 1'b1; else charge_down <= 1'b1;
    @(posedge clock);
    charge_up <= 1'b0;
    charge_down <= 1'b0;
  endtask
  // One-cycle host read of the status flags, driven on clock edges.
  task automatic read_status();
    @(posedge clock);
    status_read <= 1'b1;
    @(posedge clock);
    status_read <= 1'b0;
  endtask
  // Bounded wait; the first look is after a settled edge, never in the launching step.
  task automatic wait_seen(input logic lvl);
    int n;
    n = 0;
    tick(1);
    while (seen !== lvl && n < 300)
    begin
      tick(1);
      n++;
    end
    if (seen !== lvl)
    begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic t_reset();
    cmp16(count, gacd_pkg::COUNT_RESET);
    cmp1(pin_oe, 1'b0);
    cmp1(pin_in, 1'b1);
  endtask
  task automatic t_count();
    repeat (3) nudge(1'b1);
    tick(3);
    cmp16(count, gacd_pkg::COUNT_RESET + 16'h0003);
  endtask
  // Threshold crossing pulls the pin; the flag stays until a read after its cause is gone.
  task automatic t_alert();
    @(posedge clock);
    thresh_high <= gacd_pkg::COUNT_RESET + 16'h0001;
    tick(3);
    cmp1(status.alert_high, 1'b1);
    cmp1(pin_in, 1'b0);
    cmp1(pin_out, 1'b0);
    read_status();
    tick(2);
    cmp1(status.alert_high, 1'b1);
    @(posedge clock);
    thresh_high <= 16'hFFFF;
    tick(3);
    cmp1(pin_oe, 1'b1);
    read_status();
    tick(3);
    cmp1(status.alert_high, 1'b0);
    cmp1(pin_oe, 1'b0);
    @(posedge clock);
    undervoltage_lockout_event <= 1'b1;
    @(posedge clock);
    undervoltage_lockout_event <= 1'b0;
    tick(2);
    cmp1(status.undervoltage_lockout, 1'b1);
    cmp1(pin_oe, 1'b0);
    @(posedge clock);
    vbat_low <= 1'b1;
    @(posedge clock);
    vbat_low <= 1'b0;
    tick(3);
    cmp1(status.vbat_alert, 1'b1);
    cmp1(pin_oe, 1'b1);
    read_status();
    tick(3);
    cmp1(status.vbat_alert, 1'b0);
    cmp1(status.undervoltage_lockout, 1'b0);
    cmp1(pin_oe, 1'b0);
  endtask
  // The idle code releases the pin even with a flag set; alert mode drives it again.
  task automatic t_idle();
    @(posedge clock);
    pin_mode_sel <= gacd_pkg::PIN_MODE_DISABLED;
    thresh_low <= 16'hFFFF;
    tick(3);
    cmp1(status.alert_low, 1'b1);
    cmp1(pin_oe, 1'b0);
    @(posedge clock);
    pin_mode_sel <= gacd_pkg::PIN_MODE_ALERT;
    tick(3);
    cmp1(pin_oe, 1'b1);
    cmp1(pin_in, 1'b0);
    @(posedge clock);
    thresh_low <= 16'h0000;
    read_status();
    tick(3);
    cmp1(status.alert_low, 1'b0);
    cmp1(pin_oe, 1'b0);
  endtask
  // Minimum-width charger pulse presets the count; counting resumes only after it.
  // The charger is attached first, so the pin is low before the mode changes.
  task automatic t_charge();
    @(posedge clock);
    attached <= 1'b1;
    tick(3);
    @(posedge clock);
    pin_mode_sel <= gacd_pkg::PIN_MODE_CHARGE;
    tick(3);
    cmp16(count, gacd_pkg::COUNT_RESET + 16'h0003);
    cmp1(seen, 1'b0);
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    wait_seen(1'b1);
    cmp16(count, 16'hFFFF);
    nudge(1'b0);
    tick(2);
    cmp16(count, 16'hFFFF);
    cmp1(pin_oe, 1'b0);
    wait_seen(1'b0);
    tick(3);
    nudge(1'b0);
    tick(3);
    cmp16(count, 16'hFFFE);
    repeat (3) nudge(1'b1);
    tick(3);
    cmp16(count, 16'hFFFF);
    cmp1(status.overflow, 1'b1);
    cmp1(pin_oe, 1'b0);
  endtask
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_count();
    t_alert();
    t_idle();
    t_charge();
    give_verdict();
  end
endmodule
